//--- design/scs_pkg.sv
// Package for the clocked synchronous serial block: register map, field
// positions, reset values, state encodings and the structs that carry state.
// Assumes an APB master with 32-bit data and byte addresses on an 8-bit bus.
package scs_pkg;

    // Register byte offsets, one aligned word each
    localparam logic [7:0] SCS_OFF_MODE = 8'h00; // serial_mode_reg
    localparam logic [7:0] SCS_OFF_BAUD = 8'h04; // baud_divisor_reg
    localparam logic [7:0] SCS_OFF_CTRL = 8'h08; // serial_ctrl_reg
    localparam logic [7:0] SCS_OFF_TXH = 8'h0C; // tx_holding_reg
    localparam logic [7:0] SCS_OFF_FLAG = 8'h10; // serial_flag_reg
    localparam logic [7:0] SCS_OFF_RXH = 8'h14; // rx_holding_reg

    // serial_mode_reg fields
    localparam int SCS_MODE_SYNC_BIT = 7; // sync_mode_select
    // serial_ctrl_reg fields
    localparam int SCS_CTRL_TX_IRQ_BIT = 7; // tx_empty_irq_on
    localparam int SCS_CTRL_RX_IRQ_BIT = 6; // rx_irq_on
    localparam int SCS_CTRL_TX_ON_BIT = 5; // tx_on_switch
    localparam int SCS_CTRL_RX_ON_BIT = 4; // rx_on_switch
    localparam int SCS_CTRL_ADDR_WAIT_BIT = 3; // addr_wait_on, no effect here
    localparam int SCS_CTRL_DONE_IRQ_BIT = 2; // tx_done_irq_on
    localparam int SCS_CTRL_CLK_HI_BIT = 1; // clock_source_sel_hi
    localparam int SCS_CTRL_CLK_LO_BIT = 0; // clock_source_sel_lo
    // serial_flag_reg fields
    localparam int SCS_FLAG_TX_EMPTY_BIT = 7;
    localparam int SCS_FLAG_RX_FULL_BIT = 6;
    localparam int SCS_FLAG_OVERRUN_BIT = 5;
    localparam int SCS_FLAG_FRAMING_BIT = 4;
    localparam int SCS_FLAG_PARITY_BIT = 3;
    localparam int SCS_FLAG_TX_DONE_BIT = 2;

    // Values after reset
    localparam logic [7:0] SCS_RST_MODE = 8'h00;
    localparam logic [7:0] SCS_RST_BAUD = 8'hFF;
    localparam logic [7:0] SCS_RST_CTRL = 8'h00;
    localparam logic [7:0] SCS_RST_TXH = 8'hFF;
    localparam logic [7:0] SCS_RST_RXH = 8'h00;

    // Counts of bits and pulses per character
    localparam logic [3:0] SCS_CHAR_BITS = 4'h8;
    localparam logic [3:0] SCS_LAST_BIT = 4'h7;

    // Internal clock generator states, one-hot
    typedef enum logic [1:0] {
        SCS_CK_IDLE = 2'b01,
        SCS_CK_RUN = 2'b10
    } scs_ck_state_t;

    // Serial pin outputs
    typedef struct packed {
        logic sck_out;
        logic sck_oe;
        logic txd_out;
        logic txd_oe;
    } scs_ser_out_t;

    // Interrupt request levels
    typedef struct packed {
        logic tx_empty_irq;
        logic rx_full_irq;
        logic rx_fault_irq;
        logic tx_done_irq;
    } scs_irq_t;

    // Whole state of the block
    typedef struct packed {
        logic [7:0] serial_mode_reg;
        logic [7:0] baud_divisor_reg;
        logic [7:0] serial_ctrl_reg;
        logic [7:0] tx_holding_reg;
        logic [7:0] rx_holding_reg;
        logic tx_holding_empty_flag;
        logic rx_holding_full_flag;
        logic overrun_flag;
        logic framing_fault_flag;
        logic parity_fault_flag;
        logic tx_done_flag;
        logic [7:0] tx_shift_reg;
        logic [3:0] tx_cnt;
        logic tx_busy;
        logic txd;
        logic [7:0] rx_shift_reg;
        logic [3:0] rx_cnt;
        scs_ck_state_t ck_state;
        logic sck;
        logic [7:0] baud_cnt;
        logic [3:0] pulse_cnt;
        logic second_frame;
        logic [31:0] prdata;
        logic rxd_s1;
        logic rxd_s2;
        logic sck_s1;
        logic sck_s2;
        logic sck_s3;
    } scs_state_t;

endpackage

//--- design/scs_sync_serial.sv
// Clocked synchronous serial port with APB register access.
// Assumes pclk at 50 MHz, an APB master, and a partner on sck/txd/rxd pins.
// Overview of operation
// - Data changes on falling, valid at rising
// - Send LSB first, hold line at MSB
// - Exactly eight data bits, no extras
// - Clock source from mode and control bits
// - Internal clock drives eight pulses per character
// - Serial clock stays high when idle
// - Receive-only internal clock: two characters, sixteen pulses
// - Transmitter off sets empty flag, resets shifter
// - Receiver off keeps flags and holding data
// - Data lines used only when enabled
// - Flag cleared: load shifter, set flag, start
// - Test empty flag at bit seven
// - External clock: shift with incoming clock
// - Receive LSB first, copy or overrun
// - Receive error blocks both directions
// - Receive full and overrun raise requests
// - Independent double-buffered halves, shared clock
// - Overrun when holding still full
// - No new transmit while error flag set
//
// Register access over APB and the placing of the registers were decided locally.
module scs_sync_serial
(
    // Clock, reset and clock enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial pins, asynchronous to pclk
    input wire logic sck_in,
    input wire logic rxd_in,
    output scs_pkg::scs_ser_out_t ser_out,
    // Interrupt requests
    output scs_pkg::scs_irq_t irq
);

    scs_pkg::scs_state_t st_ff; // Registered state
    scs_pkg::scs_state_t nxt_st; // Next state
    logic internal_clk; // Baud generator drives sck
    logic external_clk; // Partner drives sck
    logic rx_err; // Any receive error flag
    logic fall_ev; // Serial clock falling edge
    logic rise_ev; // Serial clock rising edge
    logic tx_load; // Holding register moves to shifter
    logic tx_kill; // Software switches the transmitter off this cycle
    logic tx_pending; // Software has data waiting
    logic rx_only; // Receiver on, transmitter off
    logic apb_wr; // Write access phase
    logic addr_ok; // Mapped address
    logic [7:0] rd_val; // Read mux result
    logic [7:0] rx_next; // Receive shifter after this bit

    // Clock source decode
    assign internal_clk = st_ff.serial_mode_reg[scs_pkg::SCS_MODE_SYNC_BIT]
        & ~st_ff.serial_ctrl_reg[scs_pkg::SCS_CTRL_CLK_HI_BIT];
    assign external_clk = st_ff.serial_mode_reg[scs_pkg::SCS_MODE_SYNC_BIT]
        & st_ff.serial_ctrl_reg[scs_pkg::SCS_CTRL_CLK_HI_BIT];
    assign rx_err = st_ff.overrun_flag | st_ff.framing_fault_flag | st_ff.parity_fault_flag;

    // Edges: internal ones from the baud tick, external ones from the synchroniser tail
    always_comb
    begin
        fall_ev = 1'b0;
        rise_ev = 1'b0;
        if (internal_clk && st_ff.ck_state == scs_pkg::SCS_CK_RUN && st_ff.baud_cnt == 8'h00)
        begin
            fall_ev = st_ff.sck;
            rise_ev = ~st_ff.sck;
        end
        else if (external_clk)
        begin
            // Shift in step with the partner's clock
            fall_ev = st_ff.sck_s3 & ~st_ff.sck_s2;
            rise_ev = ~st_ff.sck_s3 & st_ff.sck_s2;
        end
    end

    // Transmit hand-off conditions; errors hold the transmitter back
    assign tx_pending = st_ff.serial_ctrl_reg[scs_pkg::SCS_CTRL_TX_ON_BIT]
        & ~st_ff.tx_holding_empty_flag & ~rx_err;
    // Switching off wins over a load in the same cycle, so nothing is left half-started
    assign tx_kill = apb_wr & (paddr == scs_pkg::SCS_OFF_CTRL)
        & st_ff.serial_ctrl_reg[scs_pkg::SCS_CTRL_TX_ON_BIT]
        & ~pwdata[scs_pkg::SCS_CTRL_TX_ON_BIT];
    assign tx_load = tx_pending & ~st_ff.tx_busy & ~tx_kill;
    assign rx_only = st_ff.serial_ctrl_reg[scs_pkg::SCS_CTRL_RX_ON_BIT]
        & ~st_ff.serial_ctrl_reg[scs_pkg::SCS_CTRL_TX_ON_BIT];
    assign rx_next = {st_ff.rxd_s2, st_ff.rx_shift_reg[7:1]}; // LSB arrives first

    // APB decode; zero wait states, the clock enable stalls the bus
    assign apb_wr = psel & penable & pwrite & ce;
    assign addr_ok = paddr == scs_pkg::SCS_OFF_MODE || paddr == scs_pkg::SCS_OFF_BAUD
        || paddr == scs_pkg::SCS_OFF_CTRL || paddr == scs_pkg::SCS_OFF_TXH
        || paddr == scs_pkg::SCS_OFF_FLAG || paddr == scs_pkg::SCS_OFF_RXH;
    assign pready = ce;
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata = st_ff.prdata;

    // Read mux; reserved bits read zero
    always_comb
    begin
        case (paddr)
            scs_pkg::SCS_OFF_MODE: rd_val = st_ff.serial_mode_reg;
            scs_pkg::SCS_OFF_BAUD: rd_val = st_ff.baud_divisor_reg;
            scs_pkg::SCS_OFF_CTRL: rd_val = st_ff.serial_ctrl_reg;
            scs_pkg::SCS_OFF_TXH: rd_val = st_ff.tx_holding_reg;
            scs_pkg::SCS_OFF_FLAG: rd_val = {st_ff.tx_holding_empty_flag,
                st_ff.rx_holding_full_flag, st_ff.overrun_flag, st_ff.framing_fault_flag,
                st_ff.parity_fault_flag, st_ff.tx_done_flag, 2'b00};
            scs_pkg::SCS_OFF_RXH: rd_val = st_ff.rx_holding_reg;
            default: rd_val = 8'h00;
        endcase
    end

    // Next state: software first, then hardware, so a hardware set beats a clear
    always_comb
    begin
        nxt_st = st_ff;
        // Two-flop synchronisers; the second stage feeds logic, and a third sck stage feeds edge detection
        nxt_st.rxd_s1 = rxd_in;
        nxt_st.rxd_s2 = st_ff.rxd_s1;
        nxt_st.sck_s1 = sck_in;
        nxt_st.sck_s2 = st_ff.sck_s1;
        nxt_st.sck_s3 = st_ff.sck_s2;
        // Read data captured in the setup cycle
        if (psel && !penable && !pwrite)
        begin
            nxt_st.prdata = {24'h000000, rd_val};
        end
        // Software writes
        if (apb_wr)
        begin
            case (paddr)
                scs_pkg::SCS_OFF_MODE: nxt_st.serial_mode_reg = pwdata[7:0];
                scs_pkg::SCS_OFF_BAUD: nxt_st.baud_divisor_reg = pwdata[7:0];
                scs_pkg::SCS_OFF_CTRL:
                begin
                    nxt_st.serial_ctrl_reg = pwdata[7:0];
                    // Turning the transmitter off reinitialises it at once
                    if (st_ff.serial_ctrl_reg[scs_pkg::SCS_CTRL_TX_ON_BIT]
                        && !pwdata[scs_pkg::SCS_CTRL_TX_ON_BIT])
                    begin
                        nxt_st.tx_holding_empty_flag = 1'b1;
                        nxt_st.tx_busy = 1'b0;
                        nxt_st.tx_shift_reg = 8'h00;
                        nxt_st.tx_cnt = 4'h0;
                    end
                end
                scs_pkg::SCS_OFF_TXH: nxt_st.tx_holding_reg = pwdata[7:0];
                scs_pkg::SCS_OFF_FLAG:
                begin
                    // Flags except tx_done_flag clear by writing zero; writing one leaves them
                    nxt_st.tx_holding_empty_flag = st_ff.tx_holding_empty_flag
                        & pwdata[scs_pkg::SCS_FLAG_TX_EMPTY_BIT];
                    nxt_st.rx_holding_full_flag = st_ff.rx_holding_full_flag
                        & pwdata[scs_pkg::SCS_FLAG_RX_FULL_BIT];
                    nxt_st.overrun_flag = st_ff.overrun_flag
                        & pwdata[scs_pkg::SCS_FLAG_OVERRUN_BIT];
                    nxt_st.framing_fault_flag = st_ff.framing_fault_flag
                        & pwdata[scs_pkg::SCS_FLAG_FRAMING_BIT];
                    nxt_st.parity_fault_flag = st_ff.parity_fault_flag
                        & pwdata[scs_pkg::SCS_FLAG_PARITY_BIT];
                end
                default: ;
            endcase
        end
        // Transmitter; shifts only while switched on
        if (!st_ff.serial_ctrl_reg[scs_pkg::SCS_CTRL_TX_ON_BIT] || tx_kill)
        begin
            nxt_st.tx_busy = 1'b0;
        end
        else if (tx_load)
        begin
            // Move holding to shifter and mark holding empty again
            nxt_st.tx_holding_empty_flag = 1'b1;
            nxt_st.tx_done_flag = 1'b0;
            nxt_st.tx_busy = 1'b1;
            nxt_st.tx_shift_reg = st_ff.tx_holding_reg;
            nxt_st.tx_cnt = 4'h0;
            if (fall_ev)
            begin
                // Back-to-back character: bit 0 leaves on this falling edge
                nxt_st.txd = st_ff.tx_holding_reg[0];
                nxt_st.tx_shift_reg = {1'b0, st_ff.tx_holding_reg[7:1]};
                nxt_st.tx_cnt = 4'h1;
            end
        end
        else if (st_ff.tx_busy && fall_ev && st_ff.tx_cnt < scs_pkg::SCS_CHAR_BITS)
        begin
            // One bit per falling edge, LSB first
            nxt_st.txd = st_ff.tx_shift_reg[0];
            nxt_st.tx_shift_reg = {1'b0, st_ff.tx_shift_reg[7:1]};
            nxt_st.tx_cnt = st_ff.tx_cnt + 4'h1;
            // Nothing queued at bit 7: finish and hold the line at the MSB
            if (st_ff.tx_cnt == scs_pkg::SCS_LAST_BIT && st_ff.tx_holding_empty_flag)
            begin
                nxt_st.tx_done_flag = 1'b1;
            end
        end
        else if (st_ff.tx_busy && rise_ev && st_ff.tx_cnt == scs_pkg::SCS_CHAR_BITS)
        begin
            nxt_st.tx_busy = 1'b0; // Shifter free for the next load
        end
        // Receiver: sample on rising edges while on and error-free
        if (!st_ff.serial_ctrl_reg[scs_pkg::SCS_CTRL_RX_ON_BIT])
        begin
            nxt_st.rx_cnt = 4'h0; // Flags and holding data are left alone
        end
        else if (rise_ev && !rx_err)
        begin
            nxt_st.rx_shift_reg = rx_next;
            nxt_st.rx_cnt = st_ff.rx_cnt + 4'h1;
            if (st_ff.rx_cnt == scs_pkg::SCS_LAST_BIT)
            begin
                nxt_st.rx_cnt = 4'h0;
                if (!st_ff.rx_holding_full_flag)
                begin
                    nxt_st.rx_holding_reg = rx_next;
                    nxt_st.rx_holding_full_flag = 1'b1;
                end
                else
                begin
                    nxt_st.overrun_flag = 1'b1; // Character dropped
                end
            end
        end
        // Internal clock generator: half period is divisor plus one pclk cycles
        case (st_ff.ck_state)
            scs_pkg::SCS_CK_IDLE:
            begin
                nxt_st.sck = 1'b1;
                nxt_st.baud_cnt = st_ff.baud_divisor_reg;
                nxt_st.pulse_cnt = 4'h0;
                if (internal_clk && (st_ff.tx_busy || (rx_only && !rx_err
                    && !st_ff.rx_holding_full_flag)))
                begin
                    nxt_st.ck_state = scs_pkg::SCS_CK_RUN;
                    // Receive-only bursts always carry two characters
                    nxt_st.second_frame = rx_only;
                end
            end
            scs_pkg::SCS_CK_RUN:
            begin
                if (!internal_clk)
                begin
                    nxt_st.ck_state = scs_pkg::SCS_CK_IDLE;
                    nxt_st.sck = 1'b1;
                end
                else if (st_ff.baud_cnt != 8'h00)
                begin
                    nxt_st.baud_cnt = st_ff.baud_cnt - 8'h01;
                end
                else
                begin
                    nxt_st.baud_cnt = st_ff.baud_divisor_reg;
                    nxt_st.sck = ~st_ff.sck;
                    if (!st_ff.sck)
                    begin
                        nxt_st.pulse_cnt = st_ff.pulse_cnt + 4'h1;
                        // Eighth rising edge ends a character
                        if (st_ff.pulse_cnt == scs_pkg::SCS_LAST_BIT)
                        begin
                            nxt_st.pulse_cnt = 4'h0;
                            nxt_st.second_frame = 1'b0;
                            if (!(tx_pending || (st_ff.second_frame && !rx_err)))
                            begin
                                nxt_st.ck_state = scs_pkg::SCS_CK_IDLE;
                            end
                        end
                    end
                end
            end
            default:
            begin
                nxt_st.ck_state = scs_pkg::SCS_CK_IDLE;
                nxt_st.sck = 1'b1;
            end
        endcase
    end

    // State register; the clock enable freezes everything
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff <= '0;
            st_ff.serial_mode_reg <= scs_pkg::SCS_RST_MODE;
            st_ff.baud_divisor_reg <= scs_pkg::SCS_RST_BAUD;
            st_ff.serial_ctrl_reg <= scs_pkg::SCS_RST_CTRL;
            st_ff.tx_holding_reg <= scs_pkg::SCS_RST_TXH;
            st_ff.rx_holding_reg <= scs_pkg::SCS_RST_RXH;
            st_ff.tx_holding_empty_flag <= 1'b1;
            st_ff.tx_done_flag <= 1'b1;
            st_ff.txd <= 1'b1;
            st_ff.sck <= 1'b1;
            st_ff.ck_state <= scs_pkg::SCS_CK_IDLE;
            st_ff.rxd_s1 <= 1'b1;
            st_ff.rxd_s2 <= 1'b1;
            st_ff.sck_s1 <= 1'b1;
            st_ff.sck_s2 <= 1'b1;
            st_ff.sck_s3 <= 1'b1;
        end
        else if (ce)
        begin
            st_ff <= nxt_st;
        end
    end

    // Pin drivers; sck is driven only in internal clock mode
    assign ser_out.sck_out = st_ff.sck;
    assign ser_out.sck_oe = internal_clk;
    assign ser_out.txd_out = st_ff.txd;
    assign ser_out.txd_oe = st_ff.serial_ctrl_reg[scs_pkg::SCS_CTRL_TX_ON_BIT];

    // Interrupt request levels
    assign irq.tx_empty_irq = st_ff.tx_holding_empty_flag
        & st_ff.serial_ctrl_reg[scs_pkg::SCS_CTRL_TX_IRQ_BIT];
    assign irq.rx_full_irq = st_ff.rx_holding_full_flag
        & st_ff.serial_ctrl_reg[scs_pkg::SCS_CTRL_RX_IRQ_BIT];
    assign irq.rx_fault_irq = rx_err & st_ff.serial_ctrl_reg[scs_pkg::SCS_CTRL_RX_IRQ_BIT];
    assign irq.tx_done_irq = st_ff.tx_done_flag
        & st_ff.serial_ctrl_reg[scs_pkg::SCS_CTRL_DONE_IRQ_BIT];

    // Checks on the design's own behaviour
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_sck_idle_high: assert property (
        st_ff.ck_state == scs_pkg::SCS_CK_IDLE |-> ##1 st_ff.sck || !ce)
        else $error("serial clock not high while idle");
    a_tx_off_init: assert property (
        $fell(st_ff.serial_ctrl_reg[scs_pkg::SCS_CTRL_TX_ON_BIT])
        |-> st_ff.tx_holding_empty_flag && !st_ff.tx_busy)
        else $error("transmitter off did not reinitialise");
    a_rx_hold_source: assert property (
        $changed(st_ff.rx_holding_reg)
        |-> $past(st_ff.serial_ctrl_reg[scs_pkg::SCS_CTRL_RX_ON_BIT]))
        else $error("receive holding changed while receiver off");
    a_err_blocks_full: assert property (
        $rose(st_ff.rx_holding_full_flag) |-> !$past(rx_err))
        else $error("receive full set under a receive error");
    a_overrun_no_copy: assert property (
        $rose(st_ff.overrun_flag) |-> $stable(st_ff.rx_holding_reg))
        else $error("overrun character was copied");
    a_load_marks_empty: assert property (
        tx_load && ce |=> st_ff.tx_holding_empty_flag && st_ff.tx_busy && !st_ff.tx_done_flag)
        else $error("load did not set empty flag");
    a_no_tx_on_err: assert property (
        rx_err |-> !tx_load)
        else $error("transmit started under a receive error");
    a_txd_lsb_first: assert property (
        st_ff.tx_busy && fall_ev && ce && !tx_kill && st_ff.tx_cnt < scs_pkg::SCS_CHAR_BITS
        |=> st_ff.txd == $past(st_ff.tx_shift_reg[0]))
        else $error("transmit bit order wrong");
    a_eight_pulses: assert property (
        st_ff.pulse_cnt < scs_pkg::SCS_CHAR_BITS && st_ff.tx_cnt <= scs_pkg::SCS_CHAR_BITS)
        else $error("more than eight pulses in a character");
    a_rx_full_irq: assert property (
        $rose(st_ff.rx_holding_full_flag)
        && st_ff.serial_ctrl_reg[scs_pkg::SCS_CTRL_RX_IRQ_BIT] |-> irq.rx_full_irq)
        else $error("receive full request missing");

endmodule // scs_sync_serial

//--- dv/scs_partner_model.sv
// Far-side serial device model, behavioural.
// Assumes the block drives the serial clock; the line idles high.
module scs_partner_model
(
    // Link pins
    input wire logic sck,
    input wire logic txd,
    output logic rxd,
    // Byte to send, byte seen, rising edges seen
    input wire logic [7:0] send_byte,
    output logic [7:0] got_byte,
    output int n_rise
);
    timeunit 1ns;
    timeprecision 1ps;
    int n_fall; // Falling edges so far
    // One process owns every output: next bit on each falling edge, LSB first,
    // capture on each rising edge. A rise with no fall before it is the pin
    // settling out of reset, not a clock pulse, so it is ignored.
    initial
    begin
        rxd = 1'b1;
        got_byte = 8'h00;
        n_rise = 0;
        n_fall = 0;
        forever
        begin
            @(sck);
            if (sck === 1'b0)
            begin
                rxd <= send_byte[n_fall % 8];
                n_fall <= n_fall + 1;
            end
            else if (sck === 1'b1 && n_fall > n_rise)
            begin
                got_byte <= {txd, got_byte[7:1]};
                n_rise <= n_rise + 1;
                // Flip the line after the last bit so stale data cannot pass
                if (n_rise % 8 == 7)
                begin
                    rxd <= ~rxd;
                end
            end
        end
    end
endmodule // scs_partner_model

//--- dv/scs_sync_serial_tb.sv
// Self-checking bench: APB register access, serial traffic through the model.
// Assumes internal clock mode with the model on the pins.
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value at %0t: got %h", $time, g); end end
module scs_sync_serial_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd, err;
    logic [7:0] paddr, send_byte, got_byte;
    logic [31:0] pwdata, prdata, q;
    scs_pkg::scs_ser_out_t ser_out;
    scs_pkg::scs_irq_t irq;
    wire logic sck = ser_out.sck_oe ? ser_out.sck_out : 1'b1; // Pulled up when undriven
    int n_errors = 0, n_compared = 0, n_rise;
    scs_sync_serial dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_in(sck),
        .rxd_in(rxd), .ser_out(ser_out), .irq(irq));
    scs_partner_model far (.sck(sck), .txd(ser_out.txd_out), .rxd(rxd),
        .send_byte(send_byte), .got_byte(got_byte), .n_rise(n_rise));
    // Clock, 20 ns
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // One APB transfer; result in q and err
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Poll a flag bit until set, bounded; then let the last clock pulse finish,
    // since done rises at the last falling edge, half a bit before the last capture
    task wait_flag(input int b);
        int k;
        k = 0;
        apb(1'b0, scs_pkg::SCS_OFF_FLAG, 32'h0);
        while (q[b] !== 1'b1 && k < 100)
        begin
            apb(1'b0, scs_pkg::SCS_OFF_FLAG, 32'h0);
            k++;
        end
        if (q[b] !== 1'b1)
            n_errors++;
        repeat (12) @(posedge pclk);
    endtask
    // Send one char: check the empty flag, write, then clear the flag
    task send(input logic [7:0] t, input logic [7:0] r);
        send_byte = r;
        apb(1'b0, scs_pkg::SCS_OFF_FLAG, 32'h0);
        `CHK(q[7], 1'b1)
        apb(1'b1, scs_pkg::SCS_OFF_TXH, {24'h0, t});
        apb(1'b1, scs_pkg::SCS_OFF_FLAG, 32'h7F);
    endtask
    // Verdict, single exit
    task complete_run();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        complete_run();
    end
    // Tests
    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, send_byte} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, scs_pkg::SCS_OFF_FLAG, 32'h0);
        `CHK(q, 32'h84)
        apb(1'b0, 8'h20, 32'h0);
        `CHK({err, q}, 33'h100000000)
        $display("reset test done");
        apb(1'b1, scs_pkg::SCS_OFF_CTRL, 32'h00);
        apb(1'b1, scs_pkg::SCS_OFF_MODE, 32'h80);
        apb(1'b1, scs_pkg::SCS_OFF_BAUD, 32'h04);
        repeat (12) @(posedge pclk);
        apb(1'b1, scs_pkg::SCS_OFF_CTRL, 32'h74);
        send(8'hA5, 8'h3C);
        wait_flag(2);
        `CHK({got_byte, n_rise}, {8'hA5, 32'd8})
        `CHK({sck, ser_out.txd_out, irq.tx_done_irq}, 3'b111)
        apb(1'b0, scs_pkg::SCS_OFF_RXH, 32'h0);
        `CHK(q, 32'h3C)
        apb(1'b0, scs_pkg::SCS_OFF_FLAG, 32'h0);
        `CHK({q, irq.rx_full_irq}, {32'hC4, 1'b1})
        $display("duplex test done");
        send(8'h0F, 8'h5A);
        wait_flag(2);
        apb(1'b0, scs_pkg::SCS_OFF_FLAG, 32'h0);
        `CHK({q, irq.rx_fault_irq}, {32'hE4, 1'b1})
        apb(1'b0, scs_pkg::SCS_OFF_RXH, 32'h0);
        `CHK(q, 32'h3C)
        send(8'h11, 8'h00);
        repeat (200) @(posedge pclk);
        `CHK(n_rise, 16)
        $display("overrun test done");
        apb(1'b1, scs_pkg::SCS_OFF_CTRL, 32'h44);
        apb(1'b0, scs_pkg::SCS_OFF_FLAG, 32'h0);
        `CHK({q, ser_out.txd_oe}, {32'hE4, 1'b0})
        $display("disable test done");
        // Errors cleared, both halves back on; MSB 0 shows the line held at bit 7
        apb(1'b1, scs_pkg::SCS_OFF_FLAG, 32'h87);
        apb(1'b1, scs_pkg::SCS_OFF_CTRL, 32'hF4);
        send(8'h5A, 8'h69);
        wait_flag(2);
        `CHK({got_byte, n_rise, ser_out.txd_out, irq.tx_empty_irq}, {8'h5A, 32'd24, 2'b01})
        `CHK({ser_out.sck_oe, ser_out.txd_oe}, 2'b11)
        apb(1'b0, scs_pkg::SCS_OFF_RXH, 32'h0);
        `CHK(q, 32'h69)
        $display("recovery test done");
        // Receive only: one burst of two characters, holding emptied in between
        apb(1'b1, scs_pkg::SCS_OFF_CTRL, 32'h00);
        apb(1'b1, scs_pkg::SCS_OFF_FLAG, 32'hBF);
        send_byte = 8'hC3;
        apb(1'b1, scs_pkg::SCS_OFF_CTRL, 32'h10);
        wait_flag(6);
        apb(1'b0, scs_pkg::SCS_OFF_RXH, 32'h0);
        `CHK(q, 32'hC3)
        apb(1'b1, scs_pkg::SCS_OFF_FLAG, 32'hBF);
        wait_flag(6);
        `CHK({n_rise, sck}, {32'd40, 1'b1})
        apb(1'b0, scs_pkg::SCS_OFF_RXH, 32'h0);
        `CHK(q, 32'hC3)
        $display("receive burst test done");
        complete_run();
    end
endmodule // scs_sync_serial_tb
